// ### asr_pkg.sv
// Constants for the acceleration sample output register bank.
// Assumes byte-wide register addresses from the serial port engine.
package asr_pkg;
    localparam int ADDR_W = 8;
    localparam int SAMPLE_W = 10;
    localparam int BYTE_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int AXES = 3;

    // Register addresses
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH = 8'h01;
    localparam logic [7:0] ADDR_X_LOW = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
    localparam logic [7:0] ADDR_Y_LOW = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
    localparam logic [7:0] ADDR_Z_LOW = 8'h06;
    // Control register holding the fast-read bit (kept outside this block)
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h2A;
    localparam int BIT_FAST_READ = 1;

    // Flag register fields
    localparam int BIT_ANY_OVERRUN = 7;
    localparam int BIT_Z_OVERRUN = 6;
    localparam int BIT_Y_OVERRUN = 5;
    localparam int BIT_X_OVERRUN = 4;
    localparam int BIT_ANY_FRESH = 3;
    localparam int BIT_Z_FRESH = 2;
    localparam int BIT_Y_FRESH = 1;
    localparam int BIT_X_FRESH = 0;

    // Axis indices
    localparam int AXIS_X = 0;
    localparam int AXIS_Y = 1;
    localparam int AXIS_Z = 2;

    // Reset values
    localparam logic [2:0] AXIS_FLAGS_RESET = 3'h0;
    localparam logic [9:0] SAMPLE_RESET = 10'h000;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### asr_regs.sv
// Acceleration sample output registers: flags, six data bytes, read path.
// Assumes a serial port engine issues byte reads and drains a read buffer.
// Function
// - Fast-read mode: auto-increment skips every low-byte register.
// - Normal mode: burst steps X high, X low, Y high, Y low, Z high, Z low.
// - Combined overrun flag bit 7 sets on any overwrite, clears on high reads.
// - Per-axis overrun flags, bits 6..4, set on overwrite, clear on high read.
// - Combined fresh flag bit 3 sets on any new sample, clears after high reads.
// - Per-axis fresh flags, bits 2..0, set on new sample, clear on high read.
// - Samples are 10-bit two's complement; high holds 9..2, low holds 1..0 on top.
// - Data registers sit at 0x01..0x06 right after the flag register.
// - Low byte is valid only directly after its own high-byte read.
// - High-byte read latches the matching low bits against new samples.
// - All flags read zero after reset.
// - Sample registers only update in active mode.
`timescale 1ns/1ps
module asr_regs #(
    parameter int DEPTH = asr_pkg::BUF_DEPTH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Mode
    input wire logic active,
    input wire logic fast_read,
    // Sample input
    input wire logic smp_valid,
    input wire logic [2:0] smp_axis_en,
    input wire logic [9:0] smp_x,
    input wire logic [9:0] smp_y,
    input wire logic [9:0] smp_z,
    // Read request
    input wire logic rd_req,
    input wire logic rd_load,
    input wire logic [7:0] rd_addr,
    output logic rd_ready,
    // Read data
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);

    typedef enum logic [1:0] {
        PAIR_NONE = 2'b01,
        PAIR_HELD = 2'b10
    } asr_pair_type;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    function automatic logic [2:0] high_sel(input logic [7:0] a);
        high_sel = {a == asr_pkg::ADDR_Z_HIGH, a == asr_pkg::ADDR_Y_HIGH,
                    a == asr_pkg::ADDR_X_HIGH};
    endfunction

    function automatic logic [2:0] low_sel(input logic [7:0] a);
        low_sel = {a == asr_pkg::ADDR_Z_LOW, a == asr_pkg::ADDR_Y_LOW,
                   a == asr_pkg::ADDR_X_LOW};
    endfunction

    function automatic logic [7:0] step_addr(input logic [7:0] a, input logic fast);
        logic [7:0] n;
        n = a + 8'h01;
        if (fast && (a == asr_pkg::ADDR_Z_HIGH))
            n = asr_pkg::ADDR_FLAGS;
        else if (fast && (|high_sel(a)))
            n = a + 8'h02;
        else if (a == asr_pkg::ADDR_Z_LOW)
            n = asr_pkg::ADDR_FLAGS;
        step_addr = n;
    endfunction

    // State
    logic [9:0] sample [3];
    logic [2:0] fresh;
    logic [2:0] overrun;
    logic any_fresh;
    logic any_overrun;
    logic [7:0] ptr;
    logic [1:0] shadow_bits;
    logic [2:0] shadow_axis;
    asr_pair_type pair_state;
    asr_pair_type next_pair_state;

    // Buffer
    logic [7:0] buf_mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;

    // Read decode
    wire rd_fire = rd_req && rd_ready;
    wire [7:0] cur_addr = rd_load ? rd_addr : ptr;
    wire [2:0] hi_hit = high_sel(cur_addr);
    wire [2:0] lo_hit = low_sel(cur_addr);
    wire [2:0] hi_read = rd_fire ? hi_hit : 3'h0;
    wire [7:0] next_ptr = step_addr(cur_addr, fast_read);

    // Sample and flag events
    wire [2:0] new_smp = (smp_valid && active) ? smp_axis_en : 3'h0;
    wire [2:0] keep_fresh = fresh & ~hi_read;
    wire [2:0] keep_over = overrun & ~hi_read;
    wire [2:0] lost = new_smp & keep_fresh;
    wire [2:0] next_fresh = new_smp | keep_fresh;
    wire [2:0] next_overrun = lost | keep_over;
    wire next_any_fresh = (|new_smp) | (any_fresh & (|keep_fresh));
    wire next_any_overrun = (|lost) | (any_overrun & (|keep_over));

    wire [9:0] sample_x = sample[asr_pkg::AXIS_X];
    wire [9:0] sample_y = sample[asr_pkg::AXIS_Y];
    wire [9:0] sample_z = sample[asr_pkg::AXIS_Z];
    wire [9:0] hi_sample = hi_hit[asr_pkg::AXIS_X] ? sample_x :
                           hi_hit[asr_pkg::AXIS_Y] ? sample_y : sample_z;

    wire [7:0] flag_byte = {any_overrun, overrun[asr_pkg::AXIS_Z], overrun[asr_pkg::AXIS_Y],
                            overrun[asr_pkg::AXIS_X], any_fresh, fresh[asr_pkg::AXIS_Z],
                            fresh[asr_pkg::AXIS_Y], fresh[asr_pkg::AXIS_X]};
    wire low_ok = (pair_state == PAIR_HELD) && (|lo_hit) && (lo_hit == shadow_axis);
    wire [7:0] high_byte = hi_sample[9:2];
    wire [7:0] low_byte = low_ok ? {shadow_bits, 6'h00} : asr_pkg::BYTE_ZERO;
    wire [7:0] rd_byte = (cur_addr == asr_pkg::ADDR_FLAGS) ? flag_byte :
                         (|hi_hit) ? high_byte :
                         (|lo_hit) ? low_byte : asr_pkg::BYTE_ZERO;

    // Buffer handshake; a full buffer stalls further reads
    wire buf_pop = out_valid && out_ready;
    assign rd_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = buf_mem[rd_ptr];

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Pairing of high and low reads
    always_comb
    begin
        next_pair_state = pair_state;
        case (pair_state)
            PAIR_NONE:
                if (rd_fire && (|hi_hit))
                    next_pair_state = PAIR_HELD;
            PAIR_HELD:
                if (rd_fire && !(|hi_hit))
                    next_pair_state = PAIR_NONE;
            default:
                next_pair_state = PAIR_NONE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fresh <= asr_pkg::AXIS_FLAGS_RESET;
            overrun <= asr_pkg::AXIS_FLAGS_RESET;
            any_fresh <= 1'b0;
            any_overrun <= 1'b0;
        end
        else
        begin
            fresh <= next_fresh;
            overrun <= next_overrun;
            any_fresh <= next_any_fresh;
            any_overrun <= next_any_overrun;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < asr_pkg::AXES; i++)
                sample[i] <= asr_pkg::SAMPLE_RESET;
        end
        else
        begin
            if (new_smp[asr_pkg::AXIS_X])
                sample[asr_pkg::AXIS_X] <= smp_x;
            if (new_smp[asr_pkg::AXIS_Y])
                sample[asr_pkg::AXIS_Y] <= smp_y;
            if (new_smp[asr_pkg::AXIS_Z])
                sample[asr_pkg::AXIS_Z] <= smp_z;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ptr <= asr_pkg::PTR_RESET;
            pair_state <= PAIR_NONE;
            shadow_bits <= 2'h0;
            shadow_axis <= 3'h0;
        end
        else
        begin
            pair_state <= next_pair_state;
            if (rd_fire)
                ptr <= next_ptr;
            if (rd_fire && (|hi_hit))
            begin
                shadow_bits <= hi_sample[1:0];
                shadow_axis <= hi_hit;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (rd_fire)
                wr_ptr <= wrap_inc(wr_ptr);
            if (buf_pop)
                rd_ptr <= wrap_inc(rd_ptr);
            if (rd_fire && !buf_pop)
                count <= count + CW'(1);
            else if (buf_pop && !rd_fire)
                count <= count - CW'(1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rd_fire)
            buf_mem[wr_ptr] <= rd_byte;
    end

    // Checks
    sequence s_high_x;
        rd_fire && hi_hit[asr_pkg::AXIS_X];
    endsequence

    sequence s_low_x;
        rd_fire && lo_hit[asr_pkg::AXIS_X];
    endsequence

    sequence s_high_y;
        rd_fire && hi_hit[asr_pkg::AXIS_Y];
    endsequence

    sequence s_low_y;
        rd_fire && lo_hit[asr_pkg::AXIS_Y];
    endsequence

    chk_fast_skip_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && fast_read |=> !(|low_sel(ptr)))
        else $error("fast read pointer landed on a low byte");

    chk_full_burst_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && !fast_read && (cur_addr == asr_pkg::ADDR_X_HIGH) |=> ptr == asr_pkg::ADDR_X_LOW)
        else $error("normal burst did not step to the x low byte");

    chk_burst_from_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && (cur_addr == asr_pkg::ADDR_FLAGS) |=> ptr == asr_pkg::ADDR_X_HIGH)
        else $error("burst from flags did not reach x high byte");

    chk_any_overrun_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (|(new_smp & fresh & ~hi_read)) |=> any_overrun && flag_byte[asr_pkg::BIT_ANY_OVERRUN])
        else $error("combined overrun flag missed an overwrite");

    chk_x_overrun_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        new_smp[asr_pkg::AXIS_X] && fresh[asr_pkg::AXIS_X] && !hi_read[asr_pkg::AXIS_X]
        |=> flag_byte[asr_pkg::BIT_X_OVERRUN])
        else $error("x overrun flag missed an overwrite");

    chk_any_fresh_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (|new_smp) |=> flag_byte[asr_pkg::BIT_ANY_FRESH])
        else $error("combined fresh flag missed a sample");

    chk_x_fresh_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hi_read[asr_pkg::AXIS_X] && !new_smp[asr_pkg::AXIS_X] |=> !flag_byte[asr_pkg::BIT_X_FRESH])
        else $error("x fresh flag not cleared by high read");

    chk_low_zero_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && (|lo_hit) |-> rd_byte[5:0] == 6'h00)
        else $error("low byte carries nonzero lower bits");

    chk_random_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && (|lo_hit) && (pair_state != PAIR_HELD) |-> rd_byte == asr_pkg::BYTE_ZERO)
        else $error("unpaired low read returned data");

    chk_low_wrong_axis: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_fire && (|lo_hit) && (lo_hit != shadow_axis) |-> rd_byte == asr_pkg::BYTE_ZERO)
        else $error("low read after another axis returned data");

    chk_pair_hold_x: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_high_x ##1 s_low_x |-> rd_byte[7:6] == $past(sample_x[1:0]))
        else $error("low byte does not match the latched sample");

    chk_pair_hold_y: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_high_y ##1 s_low_y |-> rd_byte[7:6] == $past(sample_y[1:0]))
        else $error("y low byte does not match the latched sample");

    chk_reset_flags: assert property (@(posedge clk_sys)
        !reset_n |-> flag_byte == asr_pkg::BYTE_ZERO)
        else $error("flags not zero during reset");

    chk_standby_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !active |=> $stable(sample_x) && $stable(sample_y) && $stable(sample_z))
        else $error("sample changed outside active mode");

endmodule // asr_regs

// ### asr_host.sv
// Host model: issues register byte reads and drains the read buffer.
// Assumes the asr_regs read handshake; drives on the falling clock edge.
`timescale 1ns/1ps
module asr_host
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Read request
    output logic rd_req,
    output logic rd_load,
    output logic [7:0] rd_addr,
    input wire logic rd_ready,
    // Read data
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready
);
    logic [7:0] got [0:7];
    int rcv = 0;
    int stall = 0;
    bit refused = 1'b0;
    initial
    begin
        rd_req = 1'b0;
        rd_load = 1'b0;
        rd_addr = 8'hFF;
        out_ready = 1'b0;
    end
    // Consumer holds off while the stall count runs down
    always @(negedge clk_sys)
    begin
        out_ready <= reset_n && (stall == 0);
        if (stall > 0)
            stall <= stall - 1;
    end
    always @(posedge clk_sys)
    begin
        if (out_valid && out_ready && rcv < 8)
        begin
            got[rcv] <= out_data;
            rcv <= rcv + 1;
        end
        if (rd_req && !rd_ready)
            refused <= 1'b1;
    end
    // First read loads the address, the rest follow the auto-increment
    task automatic burst(input logic [7:0] a, input int n, input int hold);
        int i;
        begin
            rcv = 0;
            refused = 1'b0;
            stall = hold;
            for (i = 0; i < n; i++)
            begin
                @(negedge clk_sys);
                rd_req <= 1'b1;
                rd_load <= (i == 0);
                rd_addr <= (i == 0) ? a : ~a;
                @(posedge clk_sys);
                while (!rd_ready)
                    @(posedge clk_sys);
            end
            @(negedge clk_sys);
            rd_req <= 1'b0;
            rd_load <= 1'b0;
            rd_addr <= ~rd_addr;
            for (i = 0; i < 40 && rcv < n; i++)
                @(posedge clk_sys);
            @(negedge clk_sys);
        end
    endtask
endmodule // asr_host

// ### tb.sv
// Self-checking bench for the sample output registers.
// Assumes asr_regs with the asr_host model; inputs change on the falling edge.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b1;
    logic active = 1'b1;
    logic fast_read = 1'b0;
    logic smp_valid = 1'b0;
    logic [2:0] smp_axis_en = 3'h0;
    logic [9:0] smp_x = 10'h000;
    logic [9:0] smp_y = 10'h000;
    logic [9:0] smp_z = 10'h000;
    logic rd_req, rd_load, rd_ready, out_valid, out_ready;
    logic [7:0] rd_addr, out_data;
    int bad_count = 0;
    int compares = 0;
    localparam logic [9:0] SX = 10'h2D5;
    localparam logic [9:0] SY = 10'h13E;
    localparam logic [9:0] SZ = 10'h3FF;
    initial forever #5 clk_sys = ~clk_sys;
    asr_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .active(active), .fast_read(fast_read),
        .smp_valid(smp_valid), .smp_axis_en(smp_axis_en), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
        .rd_req(rd_req), .rd_load(rd_load), .rd_addr(rd_addr), .rd_ready(rd_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    asr_host host_u (.clk_sys(clk_sys), .reset_n(reset_n), .rd_req(rd_req), .rd_load(rd_load),
        .rd_addr(rd_addr), .rd_ready(rd_ready), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready));
    function automatic logic [7:0] hi(input logic [9:0] s);
        return s[9:2];
    endfunction
    function automatic logic [7:0] lo(input logic [9:0] s);
        return {s[1:0], 6'h00};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sample(input logic [2:0] en, input logic [9:0] x, y, z);
        @(negedge clk_sys);
        smp_valid <= 1'b1;
        smp_axis_en <= en;
        {smp_x, smp_y, smp_z} <= {x, y, z};
        @(negedge clk_sys);
        smp_valid <= 1'b0;
    endtask
    task automatic t_burst();
        logic [7:0] e [0:6];
        e = '{8'h0F, hi(SX), lo(SX), hi(SY), lo(SY), hi(SZ), lo(SZ)};
        check(host_u.got[0], 8'h00);
        sample(3'h7, SX, SY, SZ);
        host_u.burst(8'h00, 7, 6);
        for (int i = 0; i < 7; i++)
            check(host_u.got[i], e[i]);
        check({7'h00, host_u.refused}, 8'h01);
        host_u.burst(8'h00, 1, 0);
        check(host_u.got[0], 8'h00);
        $display("test burst done");
    endtask
    task automatic t_overrun();
        for (int a = 0; a < 3; a++)
        begin
            sample(3'h1 << a, SX, SY, SZ);
            sample(3'h1 << a, SY, SZ, SX);
            host_u.burst(8'h00, 1, 0);
            check(host_u.got[0], 8'h88 | (8'h11 << a));
            host_u.burst(8'h01 + 8'(2 * a), 1, 0);
            host_u.burst(8'h00, 1, 0);
            check(host_u.got[0], 8'h00);
        end
        $display("test overrun done");
    endtask
    task automatic t_fast();
        fast_read <= 1'b1;
        sample(3'h7, SY, SZ, SX);
        host_u.burst(8'h00, 4, 0);
        check(host_u.got[0], 8'h0F);
        check(host_u.got[1], hi(SY));
        check(host_u.got[2], hi(SZ));
        check(host_u.got[3], hi(SX));
        fast_read <= 1'b0;
        $display("test fast done");
    endtask
    task automatic t_latch();
        sample(3'h7, SX, SY, SZ);
        host_u.burst(8'h01, 1, 0);
        sample(3'h7, SZ, SX, SY);
        host_u.burst(8'h02, 1, 0);
        check(host_u.got[0], lo(SX));
        host_u.burst(8'h04, 1, 0);
        check(host_u.got[0], 8'h00);
        host_u.burst(8'h03, 1, 0);
        host_u.burst(8'h02, 1, 0);
        check(host_u.got[0], 8'h00);
        $display("test latch done");
    endtask
    task automatic t_standby();
        @(negedge clk_sys);
        active <= 1'b0;
        sample(3'h7, SY, SY, SY);
        host_u.burst(8'h00, 7, 0);
        check(host_u.got[1], hi(SZ));
        host_u.burst(8'h00, 1, 0);
        check(host_u.got[0], 8'h00);
        host_u.burst(8'h07, 1, 0);
        check(host_u.got[0], 8'h00);
        active <= 1'b1;
        $display("test standby done");
    endtask
    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #1 reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n <= 1'b1;
        host_u.burst(8'h00, 1, 0);
        t_burst();
        t_overrun();
        t_fast();
        t_latch();
        t_standby();
        wrap_up();
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
endmodule // tb
